// file: pmg_top.sv
// Power-good status, pin control and one-shot write-unlock registers
// Register port is transaction level: one strobe stands for one complete
// host transaction, so the key clear happens on the strobe that follows
// the key write, whatever that strobe addresses. A read of the key
// register counts as that following transaction and closes the lock.
// Protected writes that arrive while locked are dropped silently; the
// host learns of it only by reading the register back.
// The status register is rebuilt from the rail indications every cycle,
// so it lags the rails by one clock. The pin sequencer works on that
// registered copy, which keeps a glitch on one rail input from reaching
// the pin in the same cycle.
// Release delays are counted in clock cycles. The counter is wide enough
// for the longest setting at the nominal clock; a faster clock needs a
// wider counter or shorter delay settings.
// Changing the delay field while waiting takes effect at once.
`timescale 1ns/1ps
`include "pmg_regs.svh"

module pmg_top #(
    parameter int unsigned            DLY0_CYC      = `PMG_DLY0_MS * `PMG_CLK_KHZ,
    parameter int unsigned            DLY1_CYC      = `PMG_DLY1_MS * `PMG_CLK_KHZ,
    parameter int unsigned            DLY2_CYC      = `PMG_DLY2_MS * `PMG_CLK_KHZ,
    parameter int unsigned            DLY3_CYC      = `PMG_DLY3_MS * `PMG_CLK_KHZ,
    parameter logic [5:0]             BUCK_ONE_CODE = 6'h1E
) (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // Transaction-level register access, one strobe per bus transaction
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [7:0]           reg_addr,
    input  wire pmg_pkg::pmg_byte_type reg_wdata,
    output logic      [7:0]           reg_rdata,
    output logic                      reg_rvalid,
    // Analog regulation indications, high while in regulation, then the two load-switch settings
    input  wire logic                 rail_three_good,
    input  wire logic                 rail_four_good,
    input  wire logic                 buck_one_good,
    input  wire logic                 buck_two_good,
    input  wire logic                 buck_three_good,
    input  wire logic                 linreg_one_good,
    input  wire logic                 linreg_two_good,
    input  wire logic                 load_switch_one,
    input  wire logic                 load_switch_two,
    // Open-drain power-good pin
    output logic                      rails_ok_output,
    output logic                      rails_ok_oe_n,
    // Buck one settings towards the converter
    output logic                      buck_one_adjust_select,
    output logic      [5:0]           buck_one_voltage_code
);
    import pmg_pkg::*;

    logic [7:0]         unlock_key_value;
    logic [7:0]         next_unlock_key_value;
    logic [7:0]         rail_good_status;
    logic [7:0]         next_rail_good_status;
    logic [7:0]         good_pin_mask_delay;
    logic [7:0]         next_good_pin_mask_delay;
    logic [7:0]         buck_one_voltage_ctrl;
    logic [7:0]         next_buck_one_voltage_ctrl;
    logic [7:0]         next_reg_rdata;
    logic               next_reg_rvalid;
    logic               xact;
    logic               unlocked;
    logic               all_good;
    pmg_pin_state_type  pin_state;
    pmg_pin_state_type  next_pin_state;
    logic [`PMG_CNT_W-1:0] dly_cnt;
    logic [`PMG_CNT_W-1:0] next_dly_cnt;
    logic [`PMG_CNT_W-1:0] dly_target;
    logic               next_rails_ok_output;

    // Any strobe marks the end of a host transaction
    // A write and a read in one cycle is outside the contract
    assign xact     = reg_wr | reg_rd;
    assign unlocked = (unlock_key_value == `PMG_KEY_UNLOCK);

    // Key register: any transaction clears the armed key, a key write reloads it
    always_comb begin
        next_unlock_key_value = unlock_key_value;
        if (xact) begin
            next_unlock_key_value = `PMG_KEY_RESET;
        end
        if (reg_wr && reg_addr == `PMG_ADDR_KEY) begin
            next_unlock_key_value = reg_wdata; // Reload wins over the clear
        end
    end

    // Protected registers accept a write only as the next transaction after an unlock
    // Reserved bits are masked on the way in, so reads show them as zero
    // Writes to the status offset and to unmapped offsets fall through here
    always_comb begin
        next_good_pin_mask_delay   = good_pin_mask_delay;
        next_buck_one_voltage_ctrl = buck_one_voltage_ctrl;
        if (reg_wr && unlocked) begin
            if (reg_addr == `PMG_ADDR_PIN_CTRL) begin
                next_good_pin_mask_delay = reg_wdata & `PMG_PC_WR_MASK;
            end else if (reg_addr == `PMG_ADDR_BUCK_ONE) begin
                next_buck_one_voltage_ctrl = reg_wdata & `PMG_B1_WR_MASK;
            end
        end
    end

    // Status snapshot, rebuilt every cycle from the rail indications
    // Reserved bit 7 stays at zero from the reset constant
    // A rail set up as a load switch always reports good
    always_comb begin
        next_rail_good_status = `PMG_STATUS_RESET;
        next_rail_good_status[`PMG_ST_RAIL_THREE]  = rail_three_good | load_switch_one;
        next_rail_good_status[`PMG_ST_RAIL_FOUR]   = rail_four_good | load_switch_two;
        next_rail_good_status[`PMG_ST_BUCK_ONE]    = buck_one_good;
        next_rail_good_status[`PMG_ST_BUCK_TWO]    = buck_two_good;
        next_rail_good_status[`PMG_ST_BUCK_THREE]  = buck_three_good;
        next_rail_good_status[`PMG_ST_LINREG_ONE]  = linreg_one_good;
        next_rail_good_status[`PMG_ST_LINREG_TWO]  = linreg_two_good;
    end

    // Read path; unmapped offsets answer zero
    // Data is zero in cycles without a read, so a stray capture shows nothing
    always_comb begin
        next_reg_rvalid = reg_rd;
        next_reg_rdata  = `PMG_BYTE_ZERO;
        if (reg_rd) begin
            if (reg_addr == `PMG_ADDR_KEY) begin
                next_reg_rdata = unlock_key_value;
            end else if (reg_addr == `PMG_ADDR_STATUS) begin
                next_reg_rdata = rail_good_status;
            end else if (reg_addr == `PMG_ADDR_PIN_CTRL) begin
                next_reg_rdata = good_pin_mask_delay;
            end else if (reg_addr == `PMG_ADDR_BUCK_ONE) begin
                next_reg_rdata = buck_one_voltage_ctrl;
            end
        end
    end

    // Pin condition uses the registered status, so it lags the rails by one cycle
    always_comb begin
        all_good = rail_good_status[`PMG_ST_RAIL_THREE] & rail_good_status[`PMG_ST_RAIL_FOUR]
                 & rail_good_status[`PMG_ST_BUCK_ONE] & rail_good_status[`PMG_ST_BUCK_TWO]
                 & rail_good_status[`PMG_ST_BUCK_THREE]
                 & (rail_good_status[`PMG_ST_LINREG_ONE]
                    | good_pin_mask_delay[`PMG_PC_MASK_ONE])
                 & (rail_good_status[`PMG_ST_LINREG_TWO]
                    | good_pin_mask_delay[`PMG_PC_MASK_TWO]);
    end

    // Delay selection from the two-bit field
    // Parameters are cut to the counter width; keep them below its range
    always_comb begin
        case (good_pin_mask_delay[`PMG_PC_DLY_HI:`PMG_PC_DLY_LO])
            2'b00:   dly_target = DLY0_CYC[`PMG_CNT_W-1:0];
            2'b01:   dly_target = DLY1_CYC[`PMG_CNT_W-1:0];
            2'b10:   dly_target = DLY2_CYC[`PMG_CNT_W-1:0];
            default: dly_target = DLY3_CYC[`PMG_CNT_W-1:0];
        endcase
    end

    // Pin sequencer: hold low, count steady good, then release
    // Any drop during the wait restarts the count from scratch
    // Counter starts at one on entry so the release lands on the target
    always_comb begin
        next_pin_state       = pin_state;
        next_dly_cnt         = dly_cnt;
        next_rails_ok_output = 1'b0;
        case (pin_state)
            PMG_PIN_LOW: begin
                next_dly_cnt = `PMG_CNT_ZERO;
                if (all_good) begin
                    next_pin_state = PMG_PIN_WAIT;
                    next_dly_cnt   = `PMG_CNT_ONE;
                end
            end
            PMG_PIN_WAIT: begin
                if (!all_good) begin
                    next_pin_state = PMG_PIN_LOW;
                    next_dly_cnt   = `PMG_CNT_ZERO;
                end else if (dly_cnt >= dly_target) begin
                    next_pin_state       = PMG_PIN_HIGH;
                    next_rails_ok_output = 1'b1;
                end else begin
                    next_dly_cnt = dly_cnt + `PMG_CNT_ONE;
                end
            end
            PMG_PIN_HIGH: begin
                // A drop pulls the pin at once; no filtering on the way down
                if (all_good) begin
                    next_rails_ok_output = 1'b1;
                end else begin
                    next_pin_state = PMG_PIN_LOW;
                    next_dly_cnt   = `PMG_CNT_ZERO;
                end
            end
            default: begin
                next_pin_state = PMG_PIN_LOW;
                next_dly_cnt   = `PMG_CNT_ZERO;
            end
        endcase
    end

    // Key register; power-up leaves the protected registers locked
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            unlock_key_value <= `PMG_KEY_RESET;
        end else begin
            unlock_key_value <= next_unlock_key_value;
        end
    end

    // Protected registers; the buck one reset code depends on the variant
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            good_pin_mask_delay   <= `PMG_PIN_CTRL_RESET;
            buck_one_voltage_ctrl <= {2'b00, BUCK_ONE_CODE};
        end else begin
            good_pin_mask_delay   <= next_good_pin_mask_delay;
            buck_one_voltage_ctrl <= next_buck_one_voltage_ctrl;
        end
    end

    // Status snapshot register; reads zero through reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rail_good_status <= `PMG_STATUS_RESET;
        end else begin
            rail_good_status <= next_rail_good_status;
        end
    end

    // Read answer registers, one cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata  <= `PMG_BYTE_ZERO;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata  <= next_reg_rdata;
            reg_rvalid <= next_reg_rvalid;
        end
    end

    // Pin sequencer state and its delay counter
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_state <= PMG_PIN_LOW;
            dly_cnt   <= `PMG_CNT_ZERO;
        end else begin
            pin_state <= next_pin_state;
            dly_cnt   <= next_dly_cnt;
        end
    end

    // Pin drive; the enable follows the level, so the pin is driven only low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rails_ok_output <= 1'b0;
            rails_ok_oe_n   <= 1'b0;
        end else begin
            rails_ok_output <= next_rails_ok_output;
            rails_ok_oe_n   <= next_rails_ok_output; // Low while pulling the pin
        end
    end

    // Buck one outputs, loaded from the next value to move with the register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            buck_one_adjust_select <= 1'b0;
            buck_one_voltage_code  <= BUCK_ONE_CODE;
        end else begin
            buck_one_adjust_select <= next_buck_one_voltage_ctrl[`PMG_B1_ADJ];
            buck_one_voltage_code  <= next_buck_one_voltage_ctrl[`PMG_B1_CODE_HI:`PMG_B1_CODE_LO];
        end
    end

endmodule

// file: pmg_regs.svh
// Register offsets, field positions, reset values and timing constants
`ifndef PMG_REGS_SVH
`define PMG_REGS_SVH

// Register offsets
`define PMG_ADDR_KEY          8'h0B
`define PMG_ADDR_STATUS       8'h0C
`define PMG_ADDR_PIN_CTRL     8'h0D
`define PMG_ADDR_BUCK_ONE     8'h0E

// Unlock key
`define PMG_KEY_UNLOCK        8'h7D
`define PMG_KEY_RESET         8'h00

// Status register bit positions
`define PMG_ST_RAIL_THREE     6
`define PMG_ST_RAIL_FOUR      5
`define PMG_ST_BUCK_ONE       4
`define PMG_ST_BUCK_TWO       3
`define PMG_ST_BUCK_THREE     2
`define PMG_ST_LINREG_ONE     1
`define PMG_ST_LINREG_TWO     0
`define PMG_STATUS_RESET      8'h00

// Pin control register fields
`define PMG_PC_MASK_ONE       3
`define PMG_PC_MASK_TWO       2
`define PMG_PC_DLY_HI         1
`define PMG_PC_DLY_LO         0
`define PMG_PC_WR_MASK        8'h0F
`define PMG_PIN_CTRL_RESET    8'h0C

// Buck one control fields
`define PMG_B1_ADJ            7
`define PMG_B1_CODE_HI        5
`define PMG_B1_CODE_LO        0
`define PMG_B1_WR_MASK        8'hBF

// Release delays in ms, clock rate in kHz
`define PMG_CLK_KHZ           125000
`define PMG_DLY0_MS           20
`define PMG_DLY1_MS           100
`define PMG_DLY2_MS           200
`define PMG_DLY3_MS           400
`define PMG_CNT_W             26
`define PMG_CNT_ZERO          26'h000_0000
`define PMG_CNT_ONE           26'h000_0001
`define PMG_BYTE_ZERO         8'h00

`endif

// file: pmg_pkg.sv
// Types shared by the power-good and write-lock register block
package pmg_pkg;

    // Power-good pin sequencing states
    typedef enum logic [1:0] {
        PMG_PIN_LOW  = 2'b00,
        PMG_PIN_WAIT = 2'b01,
        PMG_PIN_HIGH = 2'b10
    } pmg_pin_state_type;

    typedef logic [7:0] pmg_byte_type;

endpackage

// file: pmg_top_asserts.sv
// Port-level assertions for the power-good and write-lock registers
`timescale 1ns/1ps
module pmg_top_asserts #(
    parameter int unsigned DLY0_CYC = 10
) (
    input wire logic                  clk,
    input wire logic                  sys_rst,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [7:0]            reg_addr,
    input wire pmg_pkg::pmg_byte_type reg_wdata,
    input wire logic [7:0]            reg_rdata,
    input wire logic                  reg_rvalid,
    input wire logic                  buck_one_good,
    input wire logic                  buck_two_good,
    input wire logic                  buck_three_good,
    input wire logic                  load_switch_one,
    input wire logic                  rails_ok_output,
    input wire logic                  rails_ok_oe_n,
    input wire logic                  buck_one_adjust_select,
    input wire logic [5:0]            buck_one_voltage_code
);
    import pmg_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic        armed;
    int unsigned run;
    // Key armed until the next strobe; steady-good stretch of the bucks
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            armed <= 1'b0;
            run <= 0;
        end else begin
            if (reg_wr | reg_rd)
                armed <= reg_wr && reg_addr == 8'h0B && reg_wdata == 8'h7D;
            run <= (buck_one_good & buck_two_good & buck_three_good) ? run + 1 : 0;
        end
    end
    // Status reads with inputs steady, so the sampling lag cannot matter
    sequence s_stat_rd;
        reg_rd && reg_addr == 8'h0C && !$past(sys_rst) && $stable(buck_one_good);
    endsequence
    sequence s_sw_rd;
        reg_rd && reg_addr == 8'h0C && !$past(sys_rst) && load_switch_one && $past(load_switch_one);
    endsequence
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read strobe not answered");
    a_pg_upper: assert property (reg_rd && reg_addr == 8'h0D |=> reg_rdata[7:4] == 4'h0)
        else $error("pin control upper bits not zero");
    a_stat_bits: assert property (s_stat_rd |=> !reg_rdata[7] && reg_rdata[4] == $past(buck_one_good))
        else $error("status layout wrong");
    a_switch_good: assert property (s_sw_rd |=> reg_rdata[6])
        else $error("switch rail not reported good");
    a_locked_buck: assert property (reg_wr && reg_addr == 8'h0E && !armed && !$past(reg_wr)
        && !$past(reg_wr, 2) |=> $stable(buck_one_voltage_code) && $stable(buck_one_adjust_select))
        else $error("locked write changed buck one");
    a_unlock_buck: assert property (reg_wr && reg_addr == 8'h0E && armed |-> ##2
        buck_one_voltage_code == $past(reg_wdata[5:0], 2) && buck_one_adjust_select == $past(reg_wdata[7], 2))
        else $error("unlocked write not applied");
    a_pin_drop: assert property (!buck_one_good |-> ##2 !rails_ok_output)
        else $error("pin not pulled low");
    a_pin_hold: assert property ($rose(rails_ok_output) |-> run >= DLY0_CYC)
        else $error("pin released too early");
    a_oe_tracks: assert property (rails_ok_oe_n == rails_ok_output)
        else $error("pin enable disagrees with level");
endmodule

bind pmg_top pmg_top_asserts #(.DLY0_CYC(DLY0_CYC)) u_chk (.clk(clk), .sys_rst(sys_rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .buck_one_good(buck_one_good),
    .buck_two_good(buck_two_good), .buck_three_good(buck_three_good),
    .load_switch_one(load_switch_one), .rails_ok_output(rails_ok_output),
    .rails_ok_oe_n(rails_ok_oe_n), .buck_one_adjust_select(buck_one_adjust_select),
    .buck_one_voltage_code(buck_one_voltage_code));

// file: pmg_host_model.sv
// Host model issuing one register strobe per transaction
`timescale 1ns/1ps
module pmg_host_model (
    input  wire logic            clk,
    output logic                 reg_wr,
    output logic                 reg_rd,
    output logic [7:0]           reg_addr,
    output pmg_pkg::pmg_byte_type reg_wdata
);
    import pmg_pkg::*;
    logic [7:0] exp_q[$];
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'hA5;
        reg_wdata = 8'h5A;
    end
    // Strobe lasts one edge; released lines show inverted, not stale, values
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask
    // Expectation queued first so the monitor never sees an answer early
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        xfer(1'b0, a, 8'h00);
    endtask
endmodule

// file: pmg_top_tb.sv
// Self-checking bench for the power-good and write-lock registers
`timescale 1ns/1ps
module pmg_top_tb;
    import pmg_pkg::*;
    localparam logic [5:0] CODE = 6'h15;
    localparam int DLY[4] = '{10, 20, 30, 40};
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [8:0]  rails = 9'h000; // ls2 ls1 r3 r4 b1 b2 b3 l1 l2
    logic        reg_wr, reg_rd, reg_rvalid, pin, adj;
    logic [7:0]  reg_addr, reg_rdata, key;
    pmg_byte_type reg_wdata;
    logic [5:0]  code;
    logic [31:0] seed = 32'hcde5;
    int unsigned err_count = 0;
    int unsigned n_checks = 0;
    int          t;
    always #4 clk = ~clk;
    pmg_top #(.DLY0_CYC(10), .DLY1_CYC(20), .DLY2_CYC(30), .DLY3_CYC(40), .BUCK_ONE_CODE(CODE))
    uut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .rail_three_good(rails[6]), .rail_four_good(rails[5]), .buck_one_good(rails[4]),
        .buck_two_good(rails[3]), .buck_three_good(rails[2]), .linreg_one_good(rails[1]),
        .linreg_two_good(rails[0]), .load_switch_one(rails[7]), .load_switch_two(rails[8]),
        .rails_ok_output(pin), .rails_ok_oe_n(), .buck_one_adjust_select(adj),
        .buck_one_voltage_code(code));
    pmg_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Pair each read answer with the oldest expectation
    always @(posedge clk) begin
        if (reg_rvalid === 1'b1 && host.exp_q.size() > 0)
            check("read data", reg_rdata, host.exp_q.pop_front());
    end
    // Hang guard, far beyond the roughly 460 cycles of the sequence
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        host.rd(8'h0C, 8'h00);
        host.rd(8'h0D, 8'h0C);
        host.rd(8'h0E, {2'b00, CODE});
        host.wr(8'h0D, 8'hF3);
        host.rd(8'h0D, 8'h0C);
        // Fixed edge keys plus random ones, all but the unlock code
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            key = (i < 4) ? 8'h00 + 8'h7C * i[7:0] : seed[7:0] ^ 8'h02;
            if (key == 8'h7D)
                key = 8'h7C;
            host.wr(8'h0B, (i == 3) ? 8'hFF : (i == 2) ? 8'h7E : key);
            host.wr(8'h0D, 8'h00);
            host.rd(8'h0D, 8'h0C);
        end
        host.wr(8'h0B, 8'h7D);
        host.wr(8'h0E, 8'hFF);
        host.rd(8'h0E, 8'hBF);
        host.rd(8'h0B, 8'h00);
        host.wr(8'h0E, 8'h00);
        host.rd(8'h0E, 8'hBF);
        check("buck code", {adj, 1'b0, code}, 8'hBF);
        repeat (8) begin
            seed = lfsr(seed);
            @(posedge clk) rails <= seed[8:0];
            repeat (2) @(posedge clk);
            host.rd(8'h0C, {1'b0, seed[6] | seed[7], seed[5] | seed[8], seed[4:0]});
        end
        // Each delay setting with both masks cleared
        for (int d = 0; d < 4; d++) begin
            host.wr(8'h0B, 8'h7D);
            host.wr(8'h0D, d[7:0]);
            host.rd(8'h0D, d[7:0]);
            @(posedge clk) rails <= 9'h1FD;
            repeat (DLY[3] + 6) @(posedge clk);
            check("pin masked", {7'h0, pin}, 8'h00);
            @(posedge clk) rails <= 9'h1FF;
            t = 0;
            while (pin !== 1'b1 && t < 100) begin
                @(posedge clk);
                t++;
            end
            check("pin delay", {7'h0, t >= DLY[d] && t <= DLY[d] + 3}, 8'h01);
            @(posedge clk) rails <= 9'h1FE;
            repeat (3) @(posedge clk);
            check("pin drop", {7'h0, pin}, 8'h00);
        end
        repeat (4) @(posedge clk);
        check("reads pending", host.exp_q.size(), 8'h00);
        summarize();
    end
endmodule
